// file: hdl/swwe_top.sv
// watchdog supervisor core with axi4-lite register slave
//
// Functional notes
// - classify timing select at each supply rise
// - open 1600 ms, pullup 200 ms, capacitor variable
// - only falling kick edges count
// - kick late means fault output driven low
// - interval measured falling edge to falling edge
// - enable low ignores kicks, high resumes
// - enable low: echo low after 200 ns, fault released
// - enable high: both released after reset delay
// - undriven enable reads as high
// - strap low disables watchdog, may change live
// - strap rising: kicks ignored for 150 us
// - after power-on, kicks inactive, echo low 300 us
// - capacitor timeout 77.4 ms per nF plus 55
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module swwe_top
  import swwe_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // supervised pins
  input  wire logic        supply_ok,
  input  wire logic [1:0]  timing_select_pin,
  input  wire logic        disable_strap,
  input  wire logic        enable_pin,
  input  wire logic        enable_pin_driven,
  input  wire logic        kick_input,
  // open-drain outputs, low level only
  output logic             timeout_fault_n_o,
  output logic             timeout_fault_n_oe,
  output logic             enable_echo_output_o,
  output logic             enable_echo_output_oe,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  swwe_state_t      state_ff;
  swwe_tsel_t       mode_ff;
  logic [15:0]      div_ff;
  logic             tick;
  logic [CW-1:0]    phase_ff;
  logic [CW-1:0]    elapsed_ff;
  logic [7:0]       blind_ff;
  logic [7:0]       echo_cnt_ff;
  logic             echo_low_ff;
  logic             kick_prev_ff;
  logic             strap_prev_ff;
  logic             kick_fall;
  logic             kick_ok;
  logic             en_level;
  logic             strap_rise;
  logic [CW-1:0]    tmo_us;
  logic [9:0]       cap_nf_ff;
  logic [2:0]       ist_ff;
  logic [2:0]       imsk_ff;
  logic [2:0]       ev;
  logic             aw_got_ff;
  logic             w_got_ff;
  logic [7:0]       awaddr_ff;
  logic [31:0]      wdata_ff;
  logic [3:0]       wstrb_ff;
  logic             wr_go;
  logic [31:0]      rd_word;
  logic             rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning
  // a floating enable pin behaves as pulled high
  assign en_level   = enable_pin | ~enable_pin_driven;
  // only a high-to-low step is a kick; levels and rising steps are not
  assign kick_fall  = kick_prev_ff & ~kick_input;
  assign strap_rise = disable_strap & ~strap_prev_ff;

  // kicks count only while supervising, strapped on and past the blind time
  assign kick_ok = kick_fall && state_ff == ST_RUN && disable_strap
                   && blind_ff == 8'h00;

  // previous levels for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kick_prev_ff  <= 1'b0;  // idle low, so reset release is no false edge
      strap_prev_ff <= 1'b0;
    end else begin
      kick_prev_ff  <= kick_input;
      strap_prev_ff <= disable_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // microsecond timebase; one divider keeps every long count in the same unit
  always_ff @(posedge aclk) begin
    if (!aresetn || div_ff == 16'(TICK_DIV - 1)) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end
  assign tick = (div_ff == 16'(TICK_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // selected timeout in microseconds
  always_comb begin
    case (mode_ff)
      TS_OPEN:   tmo_us = CW'(TO_OPEN_US);
      TS_PULLUP: tmo_us = CW'(TO_PULL_US);
      TS_CAP:    tmo_us = CW'(32'(cap_nf_ff) * 32'(CAP_SLOPE_US) + 32'(CAP_BASE_US));
      default:   tmo_us = CW'(TO_OPEN_US);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // supervisor state machine and its phase counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_POR;
      phase_ff <= '0;
    end else if (!supply_ok) begin
      state_ff <= ST_POR;
      phase_ff <= '0;
    end else begin
      case (state_ff)
        ST_POR: begin
          // supply must hold for the startup time first
          if (tick && phase_ff == CW'(STARTUP_US - 1)) begin
            state_ff <= ST_EVAL;
            phase_ff <= '0;
          end else if (tick) begin
            phase_ff <= phase_ff + 1'b1;
          end
        end
        ST_EVAL: begin
          if (tick && phase_ff == CW'(EVAL_US - 1)) begin
            state_ff <= en_level ? ST_RSTDLY : ST_OFF;
            phase_ff <= '0;
          end else if (tick) begin
            phase_ff <= phase_ff + 1'b1;
          end
        end
        ST_OFF: begin
          if (en_level) begin
            state_ff <= ST_RSTDLY;
            phase_ff <= '0;
          end
        end
        ST_RSTDLY, ST_FAULT: begin
          if (!en_level) begin
            state_ff <= ST_OFF;
            phase_ff <= '0;
          end else if (tick && phase_ff == CW'(RST_US - 1)) begin
            state_ff <= ST_RUN;
            phase_ff <= '0;
          end else if (tick) begin
            phase_ff <= phase_ff + 1'b1;
          end
        end
        ST_RUN: begin
          if (!en_level) begin
            state_ff <= ST_OFF;
          end else if (tick && !kick_ok && disable_strap
                       && elapsed_ff >= tmo_us - 1'b1) begin
            state_ff <= ST_FAULT;
            phase_ff <= '0;
          end
        end
        default: begin
          state_ff <= ST_POR;
          phase_ff <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch the timing select class at the end of evaluation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= TS_OPEN;
    end else if (supply_ok && state_ff == ST_EVAL && tick
                 && phase_ff == CW'(EVAL_US - 1)) begin
      mode_ff <= (timing_select_pin == 2'h3) ? TS_OPEN : swwe_tsel_t'(timing_select_pin);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time since the last falling kick edge, cleared outside running supervision
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff != ST_RUN || !disable_strap) begin
      elapsed_ff <= '0;
    end else if (kick_ok || strap_rise || blind_ff != 8'h00) begin
      elapsed_ff <= '0;
    end else if (tick) begin
      elapsed_ff <= elapsed_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blind window after the strap turns supervision back on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blind_ff <= 8'h00;
    end else if (strap_rise) begin
      blind_ff <= 8'(BLIND_US);
    end else if (tick && blind_ff != 8'h00) begin
      blind_ff <= blind_ff - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // echo output drops a fixed delay after enable falls
  always_ff @(posedge aclk) begin
    if (!aresetn || en_level) begin
      echo_cnt_ff <= 8'h00;
      echo_low_ff <= 1'b0;
    end else if (echo_cnt_ff == 8'(ECHO_CYC - 1)) begin
      echo_low_ff <= 1'b1;
    end else begin
      echo_cnt_ff <= echo_cnt_ff + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain drives: enables are registered states, data always low
  assign timeout_fault_n_o     = 1'b0;
  assign enable_echo_output_o  = 1'b0;
  // fault released while disabled, low in reset delay and after a miss
  assign timeout_fault_n_oe    = (state_ff == ST_RSTDLY)
                                 || (state_ff == ST_FAULT);
  assign enable_echo_output_oe = (state_ff == ST_POR) || (state_ff == ST_EVAL)
                                 || (state_ff == ST_RSTDLY) || echo_low_ff;

  ////////////////////////////////////////////////////////////////////////////
  // events, sticky status and interrupt
  assign ev[IRQ_KICK]  = kick_ok;
  // at or past the limit: a smaller timeout written while running still trips
  assign ev[IRQ_FAULT] = (state_ff == ST_RUN) && en_level && tick && !kick_ok
                         && disable_strap && elapsed_ff >= tmo_us - 1'b1;
  assign ev[IRQ_EVAL]  = supply_ok && state_ff == ST_EVAL && tick
                         && phase_ff == CW'(EVAL_US - 1);
  // a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_ff <= 3'h0;
    end else if (wr_go && awaddr_ff == REG_IST && wstrb_ff[0]) begin
      ist_ff <= (ist_ff & ~wdata_ff[2:0]) | ev;
    end else begin
      ist_ff <= ist_ff | ev;
    end
  end
  assign irq = |(ist_ff & imsk_ff);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
  assign wr_go         = aw_got_ff && w_got_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
      end
    end
  end
  // writable registers, low bytes only carry fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_nf_ff <= CFG_RST;
      imsk_ff   <= IMSK_RST;
    end else if (wr_go) begin
      if (awaddr_ff == REG_CFG) begin
        if (wstrb_ff[0]) cap_nf_ff[7:0] <= wdata_ff[7:0];
        if (wstrb_ff[1]) cap_nf_ff[9:8] <= wdata_ff[9:8];
      end
      if (awaddr_ff == REG_IMSK && wstrb_ff[0]) begin
        imsk_ff <= wdata_ff[2:0];
      end
    end
  end
  // write response, slave error for any offset but REG_CFG, REG_IST and REG_IMSK
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_ff == REG_CFG || awaddr_ff == REG_IST
                       || awaddr_ff == REG_IMSK) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read: one read in flight, data registered
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      REG_CFG:  rd_word = {22'h0, cap_nf_ff};
      REG_STAT: rd_word = {24'h0, state_ff, mode_ff, blind_ff != 8'h00,
                           enable_echo_output_oe, timeout_fault_n_oe};
      REG_IST:  rd_word = {29'h0, ist_ff};
      REG_IMSK: rd_word = {29'h0, imsk_ff};
      REG_TMO:  rd_word = {5'h0, tmo_us};
      default:  rd_hit  = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: hdl/swwe_pkg.sv
// constants, register map and types of the standalone watchdog supervisor
package swwe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timebase
  localparam int CLK_MHZ       = 250;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_CYC      = CLK_MHZ;   // clock cycles per microsecond tick
  localparam int CW            = 27;        // width of microsecond counters

  ////////////////////////////////////////////////////////////////////////////
  // times in their own units, and counts derived from them
  localparam int T_STARTUP_US  = 300;
  localparam int T_EVAL_US     = 381;
  localparam int T_BLIND_US    = 150;
  localparam int T_ECHO_NS     = 200;
  localparam int ECHO_CYC      = (T_ECHO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RST_MS      = 200;
  localparam int T_TO_OPEN_MS  = 1600;
  localparam int T_TO_PULL_MS  = 200;
  localparam int US_PER_MS     = 1000;
  localparam int CAP_SLOPE_TMS = 774;       // 77.4 ms per nF, in tenths of ms
  localparam int CAP_BASE_MS   = 55;
  localparam int STARTUP_US    = T_STARTUP_US;
  localparam int EVAL_US       = T_EVAL_US;
  localparam int BLIND_US      = T_BLIND_US;
  localparam int RST_US        = T_RST_MS * US_PER_MS;
  localparam int TO_OPEN_US    = T_TO_OPEN_MS * US_PER_MS;
  localparam int TO_PULL_US    = T_TO_PULL_MS * US_PER_MS;
  localparam int CAP_SLOPE_US  = CAP_SLOPE_TMS * (US_PER_MS / 10);
  localparam int CAP_BASE_US   = CAP_BASE_MS * US_PER_MS;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [7:0] REG_CFG  = 8'h00;  // capacitance in nF
  localparam logic [7:0] REG_STAT = 8'h04;  // live state
  localparam logic [7:0] REG_IST  = 8'h08;  // sticky events, write one to clear
  localparam logic [7:0] REG_IMSK = 8'h0c;  // event mask
  localparam logic [7:0] REG_TMO  = 8'h10;  // selected kick timeout in us
  localparam logic [9:0] CFG_RST  = 10'h001;
  localparam logic [2:0] IMSK_RST = 3'h0;
  localparam int IRQ_KICK  = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_EVAL  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {TS_OPEN, TS_PULLUP, TS_CAP, TS_RSVD} swwe_tsel_t;
  typedef enum logic [2:0] {
    ST_POR, ST_EVAL, ST_OFF, ST_RSTDLY, ST_RUN, ST_FAULT
  } swwe_state_t;

endpackage

// file: verif/swwe_checker.sv
// port assertions for the watchdog supervisor
`timescale 1ns/1ps
module swwe_checker
  import swwe_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus answers
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // supervised pins
  input wire logic        supply_ok,
  input wire logic        enable_pin,
  input wire logic        enable_pin_driven,
  input wire logic        timeout_fault_n_oe,
  input wire logic        enable_echo_output_oe
);
  localparam int QUIET = 680 * TICK_DIV - 1;  // tick phase may lag a whole tick
  localparam int READY = 682 * TICK_DIV + 4;
  logic        en_low;
  logic [7:0]  low_ff;
  logic [19:0] up_ff;
  assign en_low = enable_pin_driven && !enable_pin;
  ////////////////////////////////////////
  // run length of enable low, saturating so long holds stay legal
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_low) begin
      low_ff <= 8'h00;
    end else if (low_ff != 8'hff) begin
      low_ff <= low_ff + 8'h01;
    end
  end
  // cycles of good supply since its last rise
  always_ff @(posedge aclk) begin
    if (!aresetn || !supply_ok) begin
      up_ff <= 20'h00000;
    end else if (up_ff != 20'hfffff) begin
      up_ff <= up_ff + 20'h00001;
    end
  end
  ////////////////////////////////////////
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_supply_low:
    assert property (!supply_ok |=> !timeout_fault_n_oe && enable_echo_output_oe)
    else $error("supply low does not force power-on pins");
  a_quiet_start:
    assert property (int'(up_ff) < QUIET |-> !timeout_fault_n_oe && enable_echo_output_oe)
    else $error("pins not quiet during start-up");
  a_fault_release:
    assert property (en_low |=> !timeout_fault_n_oe) else $error("fault held while disabled");
  a_echo_delay:
    assert property (low_ff >= 8'h34 |-> enable_echo_output_oe) else $error("echo not low");
  a_rearm_delay:
    assert property ($fell(en_low) && int'(up_ff) > READY |=>
      (timeout_fault_n_oe && enable_echo_output_oe) [*8]) else $error("no reset delay");
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_gate:
    assert property (s_axi_arready == !s_axi_rvalid) else $error("read address ready wrong");
  c_rearm: cover property ($fell(en_low) && int'(up_ff) > READY);
  c_echo: cover property (low_ff == 8'h34);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind swwe_top swwe_checker #(.TICK_DIV(TICK_DIV)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .supply_ok(supply_ok),
  .enable_pin(enable_pin), .enable_pin_driven(enable_pin_driven),
  .timeout_fault_n_oe(timeout_fault_n_oe), .enable_echo_output_oe(enable_echo_output_oe)
);

// file: verif/swwe_kick_src.sv
// model of the monitored processor issuing periodic kicks
`timescale 1ns/1ps
module swwe_kick_src (
  // clock and control
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [15:0] period,
  // kick line
  output logic             kick_input
);
  logic [15:0] cnt_ff;
  // period counter; stopping leaves a static low level, which must not count
  always_ff @(posedge aclk) begin
    if (!go || cnt_ff >= period) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  // pulse of 16 cycles (64 ns), well inside any timeout
  assign kick_input = go && (cnt_ff < 16'h0010);
endmodule

// file: verif/standard_watchdog_with_enable_bench.sv
// self-checking bench for the standard watchdog supervisor
`timescale 1ns/1ps
module standard_watchdog_with_enable_bench
  import swwe_pkg::*;
();
  localparam int TD    = 2;                               // two cycles per tick
  localparam int BOOT  = (T_STARTUP_US + T_EVAL_US) * TD; // supply rise to reset delay
  localparam int LIMIT = 20000;                           // run ceiling in cycles
  logic        aclk = 1'b0, aresetn = 1'b0, supply_ok = 1'b1, disable_strap = 1'b1;
  logic        enable_pin = 1'b1, enable_pin_driven = 1'b1, kick_go = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  timing_select_pin = 2'h0;
  logic [15:0] kick_period = 16'h0040;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        kick_input, irq, timeout_fault_n_o, timeout_fault_n_oe;
  logic        enable_echo_output_o, enable_echo_output_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$];
  logic [31:0] s_axi_rdata, tmo;
  logic [65:0] rq[$], re;   // pending reads: mask, response, data
  int          num_errors = 0, n_tests = 0, cyc = 0, n, nf;
  ////////////////////////////////////////
  // design and the processor model
  swwe_top #(.TICK_DIV(TD)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .supply_ok, .timing_select_pin, .disable_strap,
    .enable_pin, .enable_pin_driven, .kick_input, .timeout_fault_n_o, .timeout_fault_n_oe,
    .enable_echo_output_o, .enable_echo_output_oe, .irq
  );
  swwe_kick_src u_cpu (.aclk, .go(kick_go), .period(kick_period), .kick_input);
  always #2 aclk = ~aclk;
  ////////////////////////////////////////
  // compares for bus answers and pin levels
  task automatic chk_reg(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  // answers are matched against the oldest note as they appear
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      re = rq.pop_front();
      chk_reg("read", re[33:0], {s_axi_rresp, s_axi_rdata & re[65:34]});
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      chk_reg("bresp", {bq.pop_front(), 32'h0}, {s_axi_bresp, 32'h0});
    end
  end
  // bus master: each channel released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);  // a following call must not raise bready in this same step
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
    rq.push_back({m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);  // a following call must not raise rready in this same step
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////
  // main sequence
  initial begin
    n = $urandom(32'h907f);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_pin("write ready idle", 1'b1, s_axi_awready && s_axi_wready);
    rd(REG_CFG, 32'h3ff, {RESP_OKAY, 22'h0, CFG_RST});
    rd(REG_IMSK, 32'h7, {RESP_OKAY, 29'h0, IMSK_RST});
    rd(8'h14, 32'hffffffff, {RESP_SLVERR, 32'h0});
    wr(8'h14, 32'h3, RESP_SLVERR);
    $display("register test done");
    // every timing class, each after a fresh supply rise
    for (int c = 0; c < 4; c++) begin
      nf = $urandom_range(1000);
      wr(REG_CFG, 32'(nf), RESP_OKAY);
      timing_select_pin <= c[1:0];
      supply_ok <= 1'b0;
      repeat (3) @(posedge aclk);
      chk_pin("fault in power-on", 1'b0, timeout_fault_n_oe);
      chk_pin("echo in power-on", 1'b1, enable_echo_output_oe);
      supply_ok <= 1'b1;
      n = 0;
      while (!timeout_fault_n_oe && n < BOOT + 8) begin
        @(posedge aclk);
        n++;
      end
      chk_pin("start-up time", 1'b1, n >= BOOT - 2 * TD && n < BOOT + 8);
      tmo = (c == 2) ? 32'(CAP_SLOPE_US * nf + CAP_BASE_US) : (c == 1) ? 32'(TO_PULL_US)
            : 32'(TO_OPEN_US);
      rd(REG_TMO, 32'hffffffff, {RESP_OKAY, tmo});
      // select code 3 is taken as an open pin
      rd(REG_STAT, 32'hfb,
         {RESP_OKAY, 24'h0, 3'h3, ((c == 3) ? 2'h0 : c[1:0]), 1'b0, 2'h3});
      $display("start-up test %0d done", c);
    end
    // enable pulse with kicks running meanwhile
    kick_period <= 16'($urandom_range(200, 20));
    kick_go <= 1'b1;
    enable_pin <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_pin("fault released", 1'b0, timeout_fault_n_oe);
    repeat (60) @(posedge aclk);
    chk_pin("echo low", 1'b1, enable_echo_output_oe);
    chk_pin("fault data", 1'b0, timeout_fault_n_o);
    chk_pin("echo data", 1'b0, enable_echo_output_o);
    rd(REG_STAT, 32'he3, {RESP_OKAY, 24'h0, 3'h2, 5'h2});
    enable_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_pin("rearm fault", 1'b1, timeout_fault_n_oe);
    chk_pin("rearm echo", 1'b1, enable_echo_output_oe);
    enable_pin_driven <= 1'b0;
    enable_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    chk_pin("floating enable", 1'b1, timeout_fault_n_oe);
    enable_pin_driven <= 1'b1;
    disable_strap <= 1'b0;
    repeat (300) @(posedge aclk);
    disable_strap <= 1'b1;
    enable_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    // reset delay, open class, blind window running, both pins pulled low
    rd(REG_STAT, 32'hff, {RESP_OKAY, 24'h0, 8'h67});
    kick_go <= 1'b0;
    $display("enable test done");
    // kicks outside supervision leave no event; evaluation event drives irq
    chk_pin("irq masked", 1'b0, irq);
    rd(REG_IST, 32'h7, {RESP_OKAY, 32'h4});
    wr(REG_IMSK, 32'h4, RESP_OKAY);
    @(posedge aclk);
    chk_pin("irq raised", 1'b1, irq);
    wr(REG_IST, 32'h4, RESP_OKAY);
    @(posedge aclk);
    chk_pin("irq cleared", 1'b0, irq);
    $display("interrupt test done");
    test_done();
  end
endmodule
